// file: hdl/hsp_top.sv
// sideband pin control: comms gate, charger, suspend, irq, port pin, straps
`timescale 1ns/100ps
`default_nettype none
module hsp_top #(
    parameter int STRAP_WIDTH = hsp_pkg::STRAP_WIDTH
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   config_done,
    input  wire hsp_pkg::hsp_config_type config_in,
    input  wire logic                   hub_suspended,
    input  wire logic                   interrupt_pending,
    input  wire logic                   port_power_enable,
    input  wire logic                   comms_stage_request,
    input  wire logic                   irq_request_l,
    input  wire logic                   port_power_ctl_pin_in,
    input  wire logic [STRAP_WIDTH-1:0] strap_in,
    output logic                        comms_stage_active,
    output logic                        irq_active,
    output logic                        overcurrent,
    output logic                        charger_indicate_0,
    output logic                        charger_indicate_1,
    output logic                        suspend_indicate,
    output logic                        int_out_l_o,
    output logic                        int_out_l_oe,
    output logic                        port_power_ctl_pin_o,
    output logic                        port_power_ctl_pin_oe,
    output logic [STRAP_WIDTH-1:0]      strap_value
);
    hsp_pkg::hsp_pins_in_type pins_raw;
    hsp_pkg::hsp_pins_in_type pins_sync;
    hsp_pkg::hsp_stage_type   stage;
    hsp_pkg::hsp_stage_type   next_stage;
    logic                     request_prev;
    logic                     request_rise;
    logic                     strap_pending;

    // request, interrupt and sense pin inputs cross into the core clock first; straps do not
    assign pins_raw.comms_stage_request = comms_stage_request;
    assign pins_raw.irq_request_l       = irq_request_l;
    assign pins_raw.overcurrent_sense_l = port_power_ctl_pin_in;

    hsp_sync #(
        .WIDTH       (3),
        .RESET_VALUE (hsp_pkg::SYNC_RESET)
    ) u_sync (
        .clock       (clock),
        .rst_b       (rst_b),
        .async_in    (pins_raw),
        .reset_value (hsp_pkg::SYNC_RESET),
        .sync_out    (pins_sync)
    );

    // edge detect on the synchronised request only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            request_prev <= 1'b0;
        end else begin
            request_prev <= pins_sync.comms_stage_request;
        end
    end
    assign request_rise = pins_sync.comms_stage_request & ~request_prev;

    // comms stage sequencing after configuration
    always_comb begin
        next_stage = stage;
        case (stage)
            hsp_pkg::HSP_CONFIG: begin
                if (config_done) begin
                    if (pins_sync.comms_stage_request) begin
                        next_stage = hsp_pkg::HSP_COMMS;
                    end else begin
                        next_stage = hsp_pkg::HSP_WAIT_HIGH;
                    end
                end
            end
            hsp_pkg::HSP_WAIT_LOW: begin
                if (!pins_sync.comms_stage_request) begin
                    next_stage = hsp_pkg::HSP_WAIT_HIGH;
                end
            end
            hsp_pkg::HSP_WAIT_HIGH: begin
                if (request_rise) begin
                    next_stage = hsp_pkg::HSP_COMMS;
                end
            end
            hsp_pkg::HSP_COMMS: begin
                if (!pins_sync.comms_stage_request) begin
                    next_stage = hsp_pkg::HSP_WAIT_HIGH;
                end
            end
            default: begin
                next_stage = hsp_pkg::HSP_CONFIG;
            end
        endcase
        // losing configuration restarts the sequence
        if (!config_done) begin
            next_stage = hsp_pkg::HSP_CONFIG;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage <= hsp_pkg::HSP_CONFIG;
        end else begin
            stage <= next_stage;
        end
    end

    // gate by live level so a drop leaves the stage at once
    assign comms_stage_active = (stage == hsp_pkg::HSP_COMMS) &
                                pins_sync.comms_stage_request;

    // charger code and suspend from flops, data outputs other than comms_stage_active are registered
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            charger_indicate_0 <= hsp_pkg::CHARGER_RESET[0];
            charger_indicate_1 <= hsp_pkg::CHARGER_RESET[1];
        end else begin
            charger_indicate_0 <= config_in.charger_code[0];
            charger_indicate_1 <= config_in.charger_code[1];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            suspend_indicate <= 1'b0;
        end else begin
            suspend_indicate <= hub_suspended &
                                config_in.suspend_enable;
        end
    end

    // interrupt request in is active low after sync
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_active <= 1'b0;
        end else begin
            irq_active <= ~pins_sync.irq_request_l;
        end
    end

    // open drain: only ever drive low, release otherwise
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_out_l_oe <= 1'b0;
        end else begin
            int_out_l_oe <= interrupt_pending;
        end
    end
    assign int_out_l_o = 1'b0;

    // shared port pin: enable is released high by pull-up, sense is low
    // limitation: sense is meaningless while we pull the pin low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            port_power_ctl_pin_oe <= 1'b1;
            overcurrent           <= 1'b0;
        end else begin
            port_power_ctl_pin_oe <= ~port_power_enable;
            overcurrent <= port_power_enable &
                           ~pins_sync.overcurrent_sense_l;
        end
    end
    assign port_power_ctl_pin_o = 1'b0;

    // straps caught by clock on the first edge after any reset release
    // rst_b is the merged power-on and external reset (held >= 5 us)
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_pending <= 1'b1;
            strap_value   <= '0;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            strap_value   <= strap_in;
        end
    end
endmodule
`default_nettype wire

// file: hdl/hsp_pkg.sv
// constants and carrier types for the hub sideband pin control block
// Overview of operation
// - hub enters comms stage only while request input is high
// - request tied high moves hub to comms stage once configured
// - low-to-high request after configuration also enters comms stage
// - two charger outputs driven together as a configured current code
// - suspend output asserts only when the whole hub is suspended
// - suspend output stays inactive unless enabled by configuration
// - low level on interrupt request input is an active request
// - open-drain interrupt output pulls low while interrupt pending
// - one pin is open-drain port power enable and over-current sense
// - straps latched at power-on reset and external reset release
package hsp_pkg;
    localparam int          CLOCK_HZ         = 50_000_000;
    localparam int          RESET_MIN_NS     = 5_000;
    // least time rounds up to whole cycles
    localparam int          RESET_MIN_CYCLES =
        (RESET_MIN_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int          STRAP_WIDTH      = 4;
    localparam logic [1:0]  CHARGER_RESET    = 2'h0;
    // synchroniser idle levels {request, irq_l, sense_l}: low, high, high
    // so reset never fakes an interrupt or an over-current
    localparam logic [2:0]  SYNC_RESET       = 3'h3;

    typedef struct packed {
        logic       comms_stage_request;
        logic       irq_request_l;
        logic       overcurrent_sense_l;
    } hsp_pins_in_type;

    typedef struct packed {
        logic       suspend_enable;
        logic [1:0] charger_code;
    } hsp_config_type;

    typedef enum {
        HSP_CONFIG,
        HSP_WAIT_LOW,
        HSP_WAIT_HIGH,
        HSP_COMMS
    } hsp_stage_type;
endpackage

// file: hdl/hsp_sync.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module hsp_sync #(
    parameter int               WIDTH       = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_value,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // stage1 is read only by the second flop to limit metastability
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    stage1[i]   <= RESET_VALUE[i]; // idle level
                    sync_out[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
    // flops reset from the parameter so the reset branch stays constant
    logic unused_reset_value;
    assign unused_reset_value = ^reset_value;
endmodule
`default_nettype wire

// file: sim/hsp_props.sv
// assertions on the sideband pin control block ports
`timescale 1ns/100ps
`default_nettype none
module hsp_props #(
    parameter int STRAP_WIDTH = 4
) (
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire logic                    config_done,
    input wire hsp_pkg::hsp_config_type config_in,
    input wire logic                    hub_suspended,
    input wire logic                    interrupt_pending,
    input wire logic                    port_power_enable,
    input wire logic                    comms_stage_request,
    input wire logic                    irq_request_l,
    input wire logic                    port_power_ctl_pin_in,
    input wire logic [STRAP_WIDTH-1:0]  strap_in,
    input wire logic                    comms_stage_active,
    input wire logic                    irq_active,
    input wire logic                    overcurrent,
    input wire logic                    charger_indicate_0,
    input wire logic                    charger_indicate_1,
    input wire logic                    suspend_indicate,
    input wire logic                    int_out_l_oe,
    input wire logic                    port_power_ctl_pin_oe,
    input wire logic [STRAP_WIDTH-1:0]  strap_value
);
    logic [2:0] live;
    // edges since reset, so $past never reaches into reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) live <= 3'h0;
        else live <= {live[1:0], 1'h1};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // comms stage only with synced request and configuration
    property p_gate; comms_stage_active |->
        $past(comms_stage_request, 2) && $past(config_done); endproperty
    a_gate: assert property (p_gate) else $error("comms gate");
    property p_auto; (config_done && comms_stage_request)[*5] |->
        comms_stage_active; endproperty
    a_auto: assert property (p_auto) else $error("no comms");
    property p_irq; live[2] |->
        irq_active == !$past(irq_request_l, 3); endproperty
    a_irq: assert property (p_irq) else $error("irq in");
    property p_int; live[0] |->
        int_out_l_oe == $past(interrupt_pending); endproperty
    a_int: assert property (p_int) else $error("irq out");
    property p_port; live[2] |-> port_power_ctl_pin_oe == !$past(
        port_power_enable) && overcurrent == ($past(port_power_enable)
        && !$past(port_power_ctl_pin_in, 3)); endproperty
    a_port: assert property (p_port) else $error("port pin");
    property p_chg; live[0] |-> {charger_indicate_1, charger_indicate_0}
        == $past(config_in.charger_code); endproperty
    a_chg: assert property (p_chg) else $error("charger");
    property p_susp; live[0] |-> suspend_indicate == ($past(hub_suspended)
        && $past(config_in.suspend_enable)); endproperty
    a_susp: assert property (p_susp) else $error("suspend");
    property p_strap; live == 3'h1 |->
        strap_value == $past(strap_in); endproperty
    a_strap: assert property (p_strap) else $error("strap");
endmodule
bind hsp_top hsp_props #(.STRAP_WIDTH(STRAP_WIDTH)) props (
    .clock(clock), .rst_b(rst_b), .config_done(config_done),
    .config_in(config_in), .hub_suspended(hub_suspended),
    .interrupt_pending(interrupt_pending),
    .port_power_enable(port_power_enable),
    .comms_stage_request(comms_stage_request),
    .irq_request_l(irq_request_l),
    .port_power_ctl_pin_in(port_power_ctl_pin_in), .strap_in(strap_in),
    .comms_stage_active(comms_stage_active), .irq_active(irq_active),
    .overcurrent(overcurrent), .charger_indicate_0(charger_indicate_0),
    .charger_indicate_1(charger_indicate_1),
    .suspend_indicate(suspend_indicate), .int_out_l_oe(int_out_l_oe),
    .port_power_ctl_pin_oe(port_power_ctl_pin_oe),
    .strap_value(strap_value));
`default_nettype wire

// file: sim/hsp_board.sv
// board model: pulled-up port pin with power switch, interrupt line
`timescale 1ns/100ps
`default_nettype none
module hsp_board (
    input  wire logic pin_oe,
    input  wire logic pin_o,
    input  wire logic int_oe,
    input  wire logic int_o,
    input  wire logic fault,
    output logic      pin_level,
    output logic      int_level
);
    // pull-ups win when no one sinks; a tripped switch sinks the pin
    assign pin_level = (pin_oe && !pin_o) || fault ? 1'h0 : 1'h1;
    assign int_level = int_oe && !int_o ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// file: sim/hsp_top_tb.sv
// self-checking bench for the sideband pin control block
`timescale 1ns/100ps
`default_nettype none
module hsp_top_tb;
    logic clock, rst_b, config_done, hub_suspended, interrupt_pending, fault;
    logic port_power_enable, comms_stage_request, irq_request_l, c0, c1;
    logic pin_level, int_level, comms_stage_active, irq_active, overcurrent;
    logic suspend_indicate, int_o, int_oe, pin_o, pin_oe;
    logic [3:0] strap_in, strap_value;
    hsp_pkg::hsp_config_type config_in;
    int n_mismatch = 0, cmp_count = 0;
    hsp_top dut (.clock(clock), .rst_b(rst_b), .config_done(config_done),
        .config_in(config_in), .hub_suspended(hub_suspended),
        .interrupt_pending(interrupt_pending), .overcurrent(overcurrent),
        .port_power_enable(port_power_enable), .strap_in(strap_in),
        .comms_stage_request(comms_stage_request), .irq_active(irq_active),
        .irq_request_l(irq_request_l), .port_power_ctl_pin_in(pin_level),
        .comms_stage_active(comms_stage_active), .charger_indicate_0(c0),
        .charger_indicate_1(c1), .suspend_indicate(suspend_indicate),
        .int_out_l_o(int_o), .int_out_l_oe(int_oe), .strap_value(strap_value),
        .port_power_ctl_pin_o(pin_o), .port_power_ctl_pin_oe(pin_oe));
    hsp_board board (.pin_oe(pin_oe), .pin_o(pin_o), .int_oe(int_oe),
        .int_o(int_o), .fault(fault), .pin_level(pin_level),
        .int_level(int_level));
    // 50 MHz core clock
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input string what, input logic [3:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // bounded wait; running out ends the run
    task automatic wait_act(input logic lvl);
        for (int i = 0; i < 8 && comms_stage_active !== lvl; i++) cyc(1);
        chk("comms_stage_active", comms_stage_active, lvl);
        if (comms_stage_active !== lvl) wrap_up();
    endtask
    task automatic t_comms();
        comms_stage_request = 1'h1;
        cyc(6);
        chk("comms_stage_active", comms_stage_active, 1'h0);
        config_done = 1'h1;
        wait_act(1'h1);
        comms_stage_request = 1'h0;
        wait_act(1'h0);
        cyc(6);
        chk("comms_stage_active", comms_stage_active, 1'h0);
        comms_stage_request = 1'h1;
        wait_act(1'h1);
    endtask
    task automatic t_outs();
        for (int k = 0; k < 8; k++) begin
            config_in = hsp_pkg::hsp_config_type'(k[2:0]);
            hub_suspended = k[0];
            cyc(2);
            chk("charger", {c1, c0}, k[1:0]);
            chk("suspend", suspend_indicate, k[2] & k[0]);
        end
    endtask
    task automatic t_irq();
        irq_request_l = 1'h0;
        interrupt_pending = 1'h1;
        cyc(2);
        chk("irq_active", irq_active, 1'h0);
        chk("int_level", int_level, 1'h0);
        cyc(2);
        chk("irq_active", irq_active, 1'h1);
        irq_request_l = 1'h1;
        interrupt_pending = 1'h0;
        cyc(4);
        chk("irq_active", irq_active, 1'h0);
        chk("int_level", int_level, 1'h1);
    endtask
    task automatic t_port();
        cyc(2);
        chk("pin_level", pin_level, 1'h0);
        port_power_enable = 1'h1;
        fault = 1'h1;
        cyc(4);
        chk("overcurrent", overcurrent, 1'h1);
        fault = 1'h0;
        cyc(4);
        chk("pin_level", pin_level, 1'h1);
        chk("overcurrent", overcurrent, 1'h0);
    endtask
    // external reset with new straps; the short wait guards the latch
    task automatic t_straps();
        rst_b = 1'h0;
        strap_in = 4'ha;
        cyc(hsp_pkg::RESET_MIN_CYCLES);
        rst_b = 1'h1;
        cyc(2);
        strap_in = 4'h3;
        cyc(3);
        chk("strap_value", strap_value, 4'ha);
    endtask
    initial begin
        {config_done, hub_suspended, interrupt_pending, fault} = 4'h0;
        {port_power_enable, comms_stage_request} = 2'h0;
        irq_request_l = 1'h1;
        config_in = 3'h0;
        strap_in = 4'h5;
        rst_b = 1'h0;
        cyc(3);
        rst_b = 1'h1;
        cyc(2);
        chk("strap_value", strap_value, 4'h5);
        t_comms();
        t_outs();
        t_irq();
        t_port();
        t_straps();
        wrap_up();
    end
endmodule
`default_nettype wire
